// ===== rtl/urf_cfg.svh
// Constants of the USB receive FIFO control block: sizes, offsets, bit positions, reset values.
`ifndef URF_CFG_SVH
`define URF_CFG_SVH

// ***************************************************************
// Sizes
// ***************************************************************
`define URF_DEPTH 4'h8
`define URF_PTR_W 3
`define URF_CNT_W 4
`define URF_ADR_W 8
`define URF_PTR_ONE 3'h1
`define URF_CNT_ONE 4'h1
`define URF_CNT_ZERO 4'h0

// ***************************************************************
// Register indices; byte address is four times the index
// ***************************************************************
`define URF_IDX_DATA 6'h18
`define URF_IDX_CTL 6'h19
`define URF_IDX_FLG 6'h1A
`define URF_IDX_CNT 6'h1B
`define URF_IDX_LSB 2'h0

// ***************************************************************
// Field positions
// ***************************************************************
`define URF_CTL_FLUSH 7
`define URF_CTL_RDONE 4
`define URF_FLG_EMP 3
`define URF_FLG_FULL 2
`define URF_FLG_UNDER 1
`define URF_FLG_OVER 0

// ***************************************************************
// Fill values
// ***************************************************************
`define URF_BYTE_ZERO 8'h00
`define URF_PAD_ZERO 24'h00_0000
`define URF_HI_ZERO 4'h0

`endif

// ===== rtl/urf_mem.sv
// Eight-byte storage of the receive FIFO with registered, write-through read data.
`timescale 1ns/100ps
`default_nettype none
`include "urf_cfg.svh"

module urf_mem
   import urf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Write side
   input wire logic wrEn,
   input wire logic [`URF_PTR_W-1:0] wrAddr,
   input wire logic [7:0] wrData,
   // Read side
   input wire logic [`URF_PTR_W-1:0] rdAddr,
   output logic [7:0] rdData
);

   typedef struct packed {
      logic [7:0][7:0] cells;
      logic [7:0] rdData;
   } urf_mem_st_t;

   urf_mem_st_t s_q;
   urf_mem_st_t s_d;

   // Write-through so a byte pushed at the read address is seen next cycle
   always_comb begin
      s_d = s_q;
      s_d.rdData = s_q.cells[rdAddr];
      if (wrEn) begin
         s_d.cells[wrAddr] = wrData;
         if (wrAddr == rdAddr) begin
            s_d.rdData = wrData;
         end
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdData = s_q.rdData;

endmodule : urf_mem
`default_nettype wire

// ===== rtl/urf_pkg.sv
// Types shared by the USB receive FIFO control block.
package urf_pkg;

   // Register selected by a bus access
   typedef enum logic [2:0] {
      URF_REG_DATA = 3'h0,
      URF_REG_CNT = 3'h1,
      URF_REG_CTL = 3'h2,
      URF_REG_FLG = 3'h3,
      URF_REG_NONE = 3'h4
   } urf_reg_t;

   // Bus handshake phases
   typedef enum logic [1:0] {
      URF_WB_IDLE = 2'h0,
      URF_WB_WAIT = 2'h1,
      URF_WB_ACK = 2'h2
   } urf_wb_state_t;

endpackage : urf_pkg

// ===== rtl/urf_rx_fifo_ctrl.sv
// USB endpoint receive FIFO with its control, flag and byte-count registers on Wishbone.
//
// Contract
// - Setting the flush bit empties the FIFO; empty flag set, other flags cleared.
// - Hardware clears the flush bit once the flush has been done.
// - Setting the read-complete bit clears the full flag of the data set.
// - Hardware clears the read-complete bit after clearing the full flag.
// - Read-complete acts only while both setup overwrite flags are clear.
// - Empty flag tracks FIFO status: set when drained, clear when not empty.
// - Empty flag is also set when a zero-length packet is received.
// - Full flag set on successful reception; cleared when byte count is written.
// - Underrun set on reading an empty FIFO; cleared by writing zero or by a flush.
// - During underrun the read pointer stays at the empty position.
// - Overrun set when a byte is written while full; cleared by writing zero.
// - Overrun also cleared by hardware when a SETUP packet follows it.
// - During overrun the write pointer stays at the full position.
// - While underrun or overrun is set every transaction is NAKed.
// - Each written byte advances write pointer, each read byte the read pointer.
// - Interface logic stores the 4-bit data set length; firmware reads it.
// - After a byte count write, full waits for the reception acknowledge.
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "urf_cfg.svh"

module urf_rx_fifo_ctrl
   import urf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Wishbone slave
   input wire logic wbCycI,
   input wire logic wbStbI,
   input wire logic wbWeI,
   input wire logic [`URF_ADR_W-1:0] wbAdrI,
   input wire logic [3:0] wbSelI,
   input wire logic [31:0] wbDatI,
   output logic [31:0] wbDatO,
   output logic wbAckO,
   // USB system interface logic, same clock
   input wire logic usbWrStb,
   input wire logic [7:0] usbWrByte,
   input wire logic usbCntStb,
   input wire logic [`URF_CNT_W-1:0] usbCntVal,
   input wire logic usbRxAcked,
   input wire logic usbSetupRx,
   input wire logic setupOverwriteFlag,
   input wire logic setupEndOverwriteFlag,
   // Status towards the USB logic
   output logic nakAll,
   output logic rxEmptyFlag,
   output logic rxFullFlag
);

   // ***************************************************************
   // State
   // ***************************************************************

   // Every flop of the block outside the bus port and the byte storage; s_d is its next value
   typedef struct packed {
      logic [`URF_PTR_W-1:0] wrPtr;
      logic [`URF_PTR_W-1:0] rdPtr;
      logic [`URF_CNT_W-1:0] fill;
      logic [`URF_CNT_W-1:0] byteCount;
      logic flushReq;
      logic rdDoneReq;
      logic empty;
      logic full;
      logic fullPend;
      logic under;
      logic over;
      logic nak;
      logic [7:0] rdByte;
   } urf_st_t;

   // Reset state: flags as after a flush, empty set
   localparam urf_st_t URF_ST_RST = '{
      wrPtr: '0,
      rdPtr: '0,
      fill: `URF_CNT_ZERO,
      byteCount: `URF_CNT_ZERO,
      flushReq: 1'b0,
      rdDoneReq: 1'b0,
      empty: 1'b1,
      full: 1'b0,
      fullPend: 1'b0,
      under: 1'b0,
      over: 1'b0,
      nak: 1'b0,
      rdByte: `URF_BYTE_ZERO
   };

   urf_st_t s_q;
   urf_st_t s_d;

   // ***************************************************************
   // Helpers
   // ***************************************************************

   // Fill test shared by the underrun check and the empty flag
   function automatic logic fillIsZero(input logic [`URF_CNT_W-1:0] lvl);
      fillIsZero = (lvl == `URF_CNT_ZERO);
   endfunction : fillIsZero

   // Pointer step; wraps at the buffer end through its width
   function automatic logic [`URF_PTR_W-1:0] ptrStep(input logic [`URF_PTR_W-1:0] ptr);
      ptrStep = ptr + `URF_PTR_ONE;
   endfunction : ptrStep

   // No room: full flag up, or every cell taken before the count
   function automatic logic noRoom(input logic isFull, input logic [`URF_CNT_W-1:0] lvl);
      noRoom = isFull || (lvl == `URF_DEPTH);
   endfunction : noRoom

   // ***************************************************************
   // Bus port and storage
   // ***************************************************************

   logic reqGo;
   logic reqWe;
   urf_reg_t reqReg;
   logic [7:0] reqByte;
   logic [7:0] memRdData;
   logic memWrEn;
   logic [`URF_PTR_W-1:0] memWrAddr;

   // Handshake and address decode; registers are one byte, so lane 0 only
   urf_wb_port u_port (
      .clk(clk),
      .rst(rst),
      .wbCycI(wbCycI),
      .wbStbI(wbStbI),
      .wbWeI(wbWeI),
      .wbAdrI(wbAdrI),
      .wbSelI(wbSelI[0]),
      .wbDatI(wbDatI[7:0]),
      .wbAckO(wbAckO),
      .reqGo(reqGo),
      .reqWe(reqWe),
      .reqReg(reqReg),
      .reqByte(reqByte)
   );

   // Byte storage; read address is stable for a cycle before each pop
   urf_mem u_mem (
      .clk(clk),
      .rst(rst),
      .wrEn(memWrEn),
      .wrAddr(memWrAddr),
      .wrData(usbWrByte),
      .rdAddr(s_q.rdPtr),
      .rdData(memRdData)
   );

   // ***************************************************************
   // Next state
   // ***************************************************************

   // Hazards kept in mind:
   //  - the fill count, not the pointers, tells a full buffer from an empty one
   //  - a bus read is taken a cycle before it pops, so storage data has settled
   //  - an overwrite flag only delays a release; a pending one is never lost
   // Flush is applied first, then this cycle's events on top of it,
   // so a push or byte count write landing in the flush cycle is kept, not lost.
   always_comb begin
      logic busRd;
      logic busWr;
      logic popReq;
      logic pushReq;
      logic overEv;
      logic underEv;
      logic releaseNow;
      logic clrUnder;
      logic clrOver;
      busRd = 1'b0;
      busWr = 1'b0;
      popReq = 1'b0;
      pushReq = 1'b0;
      overEv = 1'b0;
      underEv = 1'b0;
      releaseNow = 1'b0;
      clrUnder = 1'b0;
      clrOver = 1'b0;
      s_d = s_q;
      memWrEn = 1'b0;
      memWrAddr = s_q.wrPtr;

      // Flush takes one cycle and then drops its own bit
      if (s_q.flushReq) begin
         s_d.wrPtr = '0;
         s_d.rdPtr = '0;
         s_d.fill = `URF_CNT_ZERO;
         s_d.full = 1'b0;
         s_d.fullPend = 1'b0;
         s_d.under = 1'b0;
         s_d.over = 1'b0;
         s_d.flushReq = 1'b0;
      end

      busRd = reqGo && !reqWe;
      busWr = reqGo && reqWe;

      // Data port read pops a byte, or flags underrun when nothing is there
      if (busRd && (reqReg == URF_REG_DATA)) begin
         if (fillIsZero(s_d.fill)) begin
            underEv = 1'b1;
         end else begin
            popReq = 1'b1;
         end
      end

      // Push from the interface logic; held off while full or at capacity
      if (usbWrStb) begin
         if (noRoom(s_d.full, s_d.fill)) begin
            overEv = 1'b1;
         end else begin
            pushReq = 1'b1;
         end
      end

      // Pointer movement; neither moves on an underrun or overrun
      if (popReq) begin
         s_d.rdPtr = ptrStep(s_d.rdPtr);
      end
      if (pushReq) begin
         memWrEn = 1'b1;
         memWrAddr = s_d.wrPtr;
         s_d.wrPtr = ptrStep(s_d.wrPtr);
      end
      if (pushReq && !popReq) begin
         s_d.fill = s_d.fill + `URF_CNT_ONE;
      end else if (popReq && !pushReq) begin
         s_d.fill = s_d.fill - `URF_CNT_ONE;
      end

      // Read data for the bus; reserved and unmapped bits read zero
      // Data port word is last cycle's storage read; the pointer has not moved
      if (busRd) begin
         case (reqReg)
            URF_REG_DATA: s_d.rdByte = memRdData;
            URF_REG_CNT: s_d.rdByte = {`URF_HI_ZERO, s_q.byteCount};
            URF_REG_CTL: begin
               s_d.rdByte = `URF_BYTE_ZERO;
               s_d.rdByte[`URF_CTL_FLUSH] = s_q.flushReq;
               s_d.rdByte[`URF_CTL_RDONE] = s_q.rdDoneReq;
            end
            URF_REG_FLG: begin
               s_d.rdByte = `URF_BYTE_ZERO;
               s_d.rdByte[`URF_FLG_EMP] = s_q.empty;
               s_d.rdByte[`URF_FLG_FULL] = s_q.full;
               s_d.rdByte[`URF_FLG_UNDER] = s_q.under;
               s_d.rdByte[`URF_FLG_OVER] = s_q.over;
            end
            default: s_d.rdByte = `URF_BYTE_ZERO;
         endcase
      end else if (busWr) begin
         s_d.rdByte = `URF_BYTE_ZERO;
      end

      // Control writes: a one starts an action, a zero does nothing
      if (busWr && (reqReg == URF_REG_CTL)) begin
         if (reqByte[`URF_CTL_FLUSH]) begin
            s_d.flushReq = 1'b1;
         end
         if (reqByte[`URF_CTL_RDONE]) begin
            s_d.rdDoneReq = 1'b1;
         end
      end

      // Flag writes: only a zero in the sticky bits has an effect
      // A one written keeps the flag; read-only and reserved bits are ignored
      if (busWr && (reqReg == URF_REG_FLG)) begin
         clrUnder = !reqByte[`URF_FLG_UNDER];
         clrOver = !reqByte[`URF_FLG_OVER];
      end

      // Release waits while a setup overwrite is flagged
      releaseNow = s_q.rdDoneReq && !setupOverwriteFlag && !setupEndOverwriteFlag;
      if (releaseNow) begin
         s_d.full = 1'b0;
         s_d.rdDoneReq = 1'b0;
      end

      // Byte count write clears full and arms it for the acknowledge
      if (usbCntStb) begin
         s_d.byteCount = usbCntVal;
         s_d.full = 1'b0;
         s_d.fullPend = 1'b1;
      end
      // Acknowledge sets full; it wins over a read-complete or count-write clear in the same cycle, not over a flush
      if (usbRxAcked && (s_d.fullPend || usbCntStb)) begin
         s_d.full = 1'b1;
         s_d.fullPend = 1'b0;
      end

      // Underrun: clear first so a same-cycle event still sets it
      if (clrUnder) begin
         s_d.under = 1'b0;
      end
      if (underEv) begin
         s_d.under = 1'b1;
      end

      // Overrun: cleared by firmware, or by a SETUP after the error
      if (clrOver || (usbSetupRx && s_q.over)) begin
         s_d.over = 1'b0;
      end
      if (overEv) begin
         s_d.over = 1'b1;
      end

      // Empty follows the fill level; a zero-length packet leaves it set
      s_d.empty = fillIsZero(s_d.fill);

      // NAK every transaction while an error flag stands
      s_d.nak = s_d.under || s_d.over;
   end

   // ***************************************************************
   // Registers and outputs
   // ***************************************************************

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= URF_ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state flops
   assign wbDatO = {`URF_PAD_ZERO, s_q.rdByte};
   assign nakAll = s_q.nak;
   assign rxEmptyFlag = s_q.empty;
   assign rxFullFlag = s_q.full;

endmodule : urf_rx_fifo_ctrl
`default_nettype wire

// ===== rtl/urf_wb_port.sv
// Classic Wishbone slave handshake: takes a request, offers it for one cycle, answers with ack.
`timescale 1ns/100ps
`default_nettype none
`include "urf_cfg.svh"

module urf_wb_port
   import urf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Wishbone request
   input wire logic wbCycI,
   input wire logic wbStbI,
   input wire logic wbWeI,
   input wire logic [`URF_ADR_W-1:0] wbAdrI,
   input wire logic wbSelI,
   input wire logic [7:0] wbDatI,
   output logic wbAckO,
   // Request towards the register file
   output logic reqGo,
   output logic reqWe,
   output urf_reg_t reqReg,
   output logic [7:0] reqByte
);

   typedef struct packed {
      urf_wb_state_t st;
      logic we;
      urf_reg_t regSel;
      logic [7:0] wrByte;
      logic ack;
   } urf_wb_st_t;

   urf_wb_st_t s_q;
   urf_wb_st_t s_d;

   // Address decode; anything else is answered but has no effect
   function automatic urf_reg_t decodeAdr(input logic [`URF_ADR_W-1:0] adr);
      case (adr)
         {`URF_IDX_DATA, `URF_IDX_LSB}: decodeAdr = URF_REG_DATA;
         {`URF_IDX_CTL, `URF_IDX_LSB}: decodeAdr = URF_REG_CTL;
         {`URF_IDX_FLG, `URF_IDX_LSB}: decodeAdr = URF_REG_FLG;
         {`URF_IDX_CNT, `URF_IDX_LSB}: decodeAdr = URF_REG_CNT;
         default: decodeAdr = URF_REG_NONE;
      endcase
   endfunction : decodeAdr

   // Handshake phases; ACK phase ignores the still-held request
   always_comb begin
      s_d = s_q;
      case (s_q.st)
         URF_WB_IDLE: begin
            s_d.ack = 1'b0;
            if (wbCycI && wbStbI) begin
               s_d.st = URF_WB_WAIT;
               s_d.we = wbWeI;
               // A write without lane 0 targets nothing, so it can never pop
               s_d.regSel = (wbWeI && !wbSelI) ? URF_REG_NONE : decodeAdr(wbAdrI);
               s_d.wrByte = wbDatI;
            end
         end
         URF_WB_WAIT: begin
            s_d.st = URF_WB_ACK;
            s_d.ack = 1'b1;
         end
         URF_WB_ACK: begin
            s_d.st = URF_WB_IDLE;
            s_d.ack = 1'b0;
         end
         default: begin
            s_d.st = URF_WB_IDLE;
            s_d.ack = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= {URF_WB_IDLE, 1'b0, URF_REG_NONE, `URF_BYTE_ZERO, 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign wbAckO = s_q.ack;
   assign reqGo = (s_q.st == URF_WB_WAIT);
   assign reqWe = s_q.we;
   assign reqReg = s_q.regSel;
   assign reqByte = s_q.wrByte;

endmodule : urf_wb_port
`default_nettype wire

// ===== testbench/urf_rx_fifo_ctrl_sva.sv
// Port-level assertions of the receive FIFO control block.
`timescale 1ns/100ps
`default_nettype none
`include "urf_cfg.svh"

module urf_rx_fifo_ctrl_sva
   import urf_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bus
   input wire logic wbCycI,
   input wire logic wbStbI,
   input wire logic wbWeI,
   input wire logic [`URF_ADR_W-1:0] wbAdrI,
   input wire logic [3:0] wbSelI,
   input wire logic [31:0] wbDatI,
   input wire logic wbAckO,
   // USB side and status
   input wire logic usbWrStb,
   input wire logic usbCntStb,
   input wire logic usbRxAcked,
   input wire logic setupOverwriteFlag,
   input wire logic setupEndOverwriteFlag,
   input wire logic nakAll,
   input wire logic rxEmptyFlag,
   input wire logic rxFullFlag
);
   // Control write being answered; its effect lands at the next edge
   logic ctlWr;
   assign ctlWr = wbAckO && wbWeI && wbSelI[0] && wbAdrI == 8'h64;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_ackPulse; wbAckO |=> !wbAckO; endproperty
   a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");
   property p_ackTime; $rose(wbStbI) && wbCycI |=> !wbAckO ##1 wbAckO; endproperty
   a_ackTime: assert property (p_ackTime) else $error("ack latency wrong");
   property p_under; $rose(wbStbI) && !wbWeI && wbAdrI == 8'h60 && rxEmptyFlag && !usbWrStb |-> ##[1:3] nakAll;
   endproperty
   a_under: assert property (p_under) else $error("empty read did not nak");
   property p_flush; ctlWr && wbDatI[7] && !usbWrStb && !usbRxAcked |=> rxEmptyFlag && !rxFullFlag ##1 !nakAll;
   endproperty
   a_flush: assert property (p_flush) else $error("flush left flags");
   property p_rdone; ctlWr && wbDatI[4] && !setupOverwriteFlag && !setupEndOverwriteFlag && !usbRxAcked
      |=> !rxFullFlag; endproperty
   a_rdone: assert property (p_rdone) else $error("read complete kept full");
   property p_block; rxFullFlag && (setupOverwriteFlag || setupEndOverwriteFlag) && !usbCntStb && !wbStbI
      |=> rxFullFlag; endproperty
   a_block: assert property (p_block) else $error("full dropped while blocked");
   property p_over; usbWrStb && rxFullFlag && !usbCntStb |=> nakAll; endproperty
   a_over: assert property (p_over) else $error("push on full did not nak");
   property p_fill; usbWrStb && rxEmptyFlag && !rxFullFlag |=> !rxEmptyFlag; endproperty
   a_fill: assert property (p_fill) else $error("empty stayed after push");
   property p_cntClr; usbCntStb && !usbRxAcked |=> !rxFullFlag; endproperty
   a_cntClr: assert property (p_cntClr) else $error("count write kept full");
   property p_noAck; !usbRxAcked && !rxFullFlag |=> !rxFullFlag; endproperty
   a_noAck: assert property (p_noAck) else $error("full rose without ack");
   property p_ackFull; usbCntStb ##1 usbRxAcked |=> rxFullFlag; endproperty
   a_ackFull: assert property (p_ackFull) else $error("ack did not set full");
endmodule : urf_rx_fifo_ctrl_sva

bind urf_rx_fifo_ctrl urf_rx_fifo_ctrl_sva urf_rx_fifo_ctrl_sva_inst (.clk, .rst, .wbCycI, .wbStbI, .wbWeI,
   .wbAdrI, .wbSelI, .wbDatI, .wbAckO, .usbWrStb, .usbCntStb, .usbRxAcked, .setupOverwriteFlag,
   .setupEndOverwriteFlag, .nakAll, .rxEmptyFlag, .rxFullFlag);
`default_nettype wire

// ===== testbench/urf_rx_fifo_ctrl_tb_top.sv
// Self-checking testbench of the receive FIFO control block.
`timescale 1ns/100ps
`default_nettype none
`include "urf_cfg.svh"

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module urf_rx_fifo_ctrl_tb_top
   import urf_pkg::*;
;
   localparam logic [7:0] aDat = 8'h60;
   localparam logic [7:0] aCtl = 8'h64;
   localparam logic [7:0] aFlg = 8'h68;
   localparam logic [7:0] aCnt = 8'h6C;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wbCycI = 1'b0;
   logic wbStbI = 1'b0;
   logic wbWeI = 1'b0;
   logic [7:0] wbAdrI = 8'h00;
   logic [3:0] wbSelI = 4'h1;
   logic [31:0] wbDatI = 32'h0000_0000;
   logic [31:0] wbDatO;
   logic wbAckO;
   logic usbWrStb, usbCntStb, usbRxAcked, usbSetupRx, nakAll, rxEmptyFlag, rxFullFlag;
   logic [7:0] usbWrByte;
   logic [3:0] usbCntVal;
   logic setupOverwriteFlag = 1'b0;
   logic setupEndOverwriteFlag = 1'b0;
   logic [31:0] rdq;
   int n_fail = 0;
   int comparisons = 0;

   // 40 MHz clock
   always #12.5 clk = ~clk;

   urf_rx_fifo_ctrl urf_rx_fifo_ctrl_inst (.clk, .rst, .wbCycI, .wbStbI, .wbWeI, .wbAdrI, .wbSelI, .wbDatI,
      .wbDatO, .wbAckO, .usbWrStb, .usbWrByte, .usbCntStb, .usbCntVal, .usbRxAcked, .usbSetupRx,
      .setupOverwriteFlag, .setupEndOverwriteFlag, .nakAll, .rxEmptyFlag, .rxFullFlag);
   urf_usb_model urf_usb_model_inst (.clk, .usbWrStb, .usbWrByte, .usbCntStb, .usbCntVal, .usbRxAcked,
      .usbSetupRx);

   // ***************************************************************
   // Bus tasks
   // ***************************************************************
   // Request held until ack is sampled; released address shows the inverse
   task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [7:0] d);
      @(posedge clk);
      wbCycI <= 1'b1;
      wbStbI <= 1'b1;
      wbWeI <= we;
      wbAdrI <= adr;
      wbDatI <= {24'h00_0000, d};
      do begin
         @(posedge clk);
      end while (wbAckO !== 1'b1);
      rdq = wbDatO;
      wbCycI <= 1'b0;
      wbStbI <= 1'b0;
      wbWeI <= 1'b0;
      wbAdrI <= ~adr;
   endtask : wbXfer

   task automatic chkReg(input logic [7:0] adr, input logic [7:0] e, input string nm);
      wbXfer(1'b0, adr, 8'h00);
      `CHK(nm, {24'h00_0000, e}, rdq)
   endtask : chkReg

   // Pops n bytes expecting base, base+1, ...
   task automatic readSeq(input int n, input logic [7:0] base);
      for (int i = 0; i < n; i++) begin
         chkReg(aDat, base + 8'(i), "data");
      end
   endtask : readSeq

   task automatic endTest(input string nm);
      $display("Test %s done", nm);
   endtask : endTest

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   // Hang guard, far beyond the few hundred cycles the tests take
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      complete_run();
   end

   // ***************************************************************
   // Tests
   // ***************************************************************
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      chkReg(aFlg, 8'h08, "flags rst");
      chkReg(aCtl, 8'h00, "ctl rst");
      chkReg(aCnt, 8'h00, "cnt rst");
      chkReg(8'h70, 8'h00, "unmapped");
      endTest("reset");
      urf_usb_model_inst.pushBytes(3, 8'h10);
      urf_usb_model_inst.endPkt(4'h3, 1'b1);
      chkReg(aFlg, 8'h04, "flags rx");
      `CHK("full pin", 1'b1, rxFullFlag)
      chkReg(aCnt, 8'h03, "count");
      readSeq(3, 8'h10);
      chkReg(aFlg, 8'h0C, "drained");
      `CHK("empty pin", 1'b1, rxEmptyFlag)
      wbXfer(1'b1, aCtl, 8'h10);
      chkReg(aCtl, 8'h00, "rdone bit");
      chkReg(aFlg, 8'h08, "released");
      endTest("packet");
      urf_usb_model_inst.pushBytes(2, 8'h20);
      urf_usb_model_inst.endPkt(4'h2, 1'b1);
      readSeq(2, 8'h20);
      setupOverwriteFlag <= 1'b1;
      wbXfer(1'b1, aCtl, 8'h10);
      chkReg(aCtl, 8'h10, "rdone held");
      setupOverwriteFlag <= 1'b0;
      setupEndOverwriteFlag <= 1'b1;
      chkReg(aFlg, 8'h0C, "full held");
      setupEndOverwriteFlag <= 1'b0;
      chkReg(aFlg, 8'h08, "late release");
      chkReg(aCtl, 8'h00, "rdone late");
      endTest("blocked release");
      wbXfer(1'b0, aDat, 8'h00);
      chkReg(aFlg, 8'h0A, "underrun");
      `CHK("nak urf", 1'b1, nakAll)
      wbXfer(1'b1, aFlg, 8'h02);
      chkReg(aFlg, 8'h0A, "urf kept");
      wbXfer(1'b1, aFlg, 8'h00);
      chkReg(aFlg, 8'h08, "urf clr");
      `CHK("nak off", 1'b0, nakAll)
      urf_usb_model_inst.pushBytes(1, 8'h5A);
      chkReg(aDat, 8'h5A, "after urf");
      endTest("underrun");
      urf_usb_model_inst.pushBytes(8, 8'h30);
      urf_usb_model_inst.endPkt(4'h8, 1'b1);
      urf_usb_model_inst.pushBytes(1, 8'hEE);
      chkReg(aFlg, 8'h05, "overrun");
      `CHK("nak ovf", 1'b1, nakAll)
      urf_usb_model_inst.setupPulse();
      chkReg(aFlg, 8'h04, "setup clr");
      wbSelI <= 4'h0;
      wbXfer(1'b1, aDat, 8'h00);
      wbSelI <= 4'h1;
      chkReg(aDat, 8'h30, "first kept");
      urf_usb_model_inst.pushBytes(1, 8'hEE);
      chkReg(aFlg, 8'h05, "ovf again");
      wbXfer(1'b1, aCtl, 8'h80);
      chkReg(aCtl, 8'h00, "flush bit");
      chkReg(aFlg, 8'h08, "flushed");
      `CHK("nak flush", 1'b0, nakAll)
      urf_usb_model_inst.pushBytes(2, 8'h40);
      urf_usb_model_inst.endPkt(4'h2, 1'b1);
      readSeq(2, 8'h40);
      endTest("overrun flush");
      urf_usb_model_inst.endPkt(4'h0, 1'b0);
      chkReg(aFlg, 8'h08, "cnt clears");
      urf_usb_model_inst.endPkt(4'h0, 1'b1);
      chkReg(aFlg, 8'h0C, "zero len");
      chkReg(aCnt, 8'h00, "zero cnt");
      endTest("zero length");
      complete_run();
   end
endmodule : urf_rx_fifo_ctrl_tb_top
`default_nettype wire

// ===== testbench/urf_usb_model.sv
// Behavioural model of the USB interface logic that feeds the receive FIFO.
`timescale 1ns/100ps
`default_nettype none
`include "urf_cfg.svh"

module urf_usb_model
   import urf_pkg::*;
(
   // Clock
   input wire logic clk,
   // Towards the block
   output logic usbWrStb,
   output logic [7:0] usbWrByte,
   output logic usbCntStb,
   output logic [`URF_CNT_W-1:0] usbCntVal,
   output logic usbRxAcked,
   output logic usbSetupRx
);
   // Idle at time zero
   initial begin
      usbWrStb = 1'b0;
      usbWrByte = 8'h00;
      usbCntStb = 1'b0;
      usbCntVal = 4'h0;
      usbRxAcked = 1'b0;
      usbSetupRx = 1'b0;
   end

   // Back-to-back pushes; released data shows the inverse so stale bytes never look valid
   task automatic pushBytes(input int n, input logic [7:0] base);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         usbWrStb <= 1'b1;
         usbWrByte <= base + 8'(i);
      end
      @(posedge clk);
      usbWrStb <= 1'b0;
      usbWrByte <= ~usbWrByte;
   endtask : pushBytes

   // Length store, then the reception acknowledge one cycle later
   task automatic endPkt(input logic [3:0] n, input logic ack);
      @(posedge clk);
      usbCntStb <= 1'b1;
      usbCntVal <= n;
      @(posedge clk);
      usbCntStb <= 1'b0;
      usbCntVal <= ~n;
      usbRxAcked <= ack;
      @(posedge clk);
      usbRxAcked <= 1'b0;
   endtask : endPkt

   // One SETUP arrival
   task automatic setupPulse();
      @(posedge clk);
      usbSetupRx <= 1'b1;
      @(posedge clk);
      usbSetupRx <= 1'b0;
   endtask : setupPulse
endmodule : urf_usb_model
`default_nettype wire
